// ### design/qpu_filter.sv
// Purpose: synchroniser and stability filter for one encoder input
// Assumes: input is asynchronous to mclk
// Notes:   three stages, change seen when second and third agree
`timescale 1ns/1ps
module qpu_filter #(
    parameter int FW = 16
) (
    input  wire logic          mclk,     // peripheral clock
    input  wire logic          rst,      // async reset, high
    input  wire logic          din,      // raw pin
    input  wire logic [FW-1:0] flt_len,  // stable cycles needed, minus one
    output logic               dout      // filtered level
);
    import qpu_pkg::*;

    logic          s1_reg;
    logic          s2_reg;
    logic          s3_reg;
    logic [FW-1:0] cnt_reg;

    // ****************************************************************
    // synchroniser; s1 feeds only s2
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ****************************************************************
    // stability counter
    // ****************************************************************
    // new level after flt_len+1 stable cycles [R11]
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            dout    <= 1'b0;
        end else if (s2_reg != s3_reg || s3_reg == dout) begin
            cnt_reg <= '0;  // bounce restarts the wait
        end else if (cnt_reg >= flt_len) begin
            dout    <= s3_reg;  // [R11]
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

// ### design/qpu_map.svh
// Purpose: offsets, field positions and reset values
// Assumes: word addresses on the plain register port
// Notes:   included by the package, the checker and the bench
`ifndef QPU_MAP_SVH
`define QPU_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define QPU_AW           5
`define QPU_OFS_CTRL     5'h00
`define QPU_OFS_CONF     5'h01
`define QPU_OFS_FILT     5'h02
`define QPU_OFS_POS      5'h03
`define QPU_OFS_MAXPOS   5'h04
`define QPU_OFS_CMP0     5'h05
`define QPU_OFS_CMP1     5'h06
`define QPU_OFS_CMP2     5'h07
`define QPU_OFS_IDX      5'h08
`define QPU_OFS_IDXCMP   5'h09
`define QPU_OFS_VLOAD    5'h0a
`define QPU_OFS_VTIME    5'h0b
`define QPU_OFS_VEL      5'h0c
`define QPU_OFS_VCAP     5'h0d
`define QPU_OFS_VCMP     5'h0e
`define QPU_OFS_DIR      5'h0f
`define QPU_OFS_STAT     5'h10
`define QPU_OFS_CLR      5'h11
`define QPU_OFS_IEN      5'h12

// ****************************************************************
// field positions
// ****************************************************************
`define QPU_CTRL_RESP    0
`define QPU_CTRL_RESI    1
`define QPU_CTRL_RESV    2
`define QPU_CONF_DIRINV  0
`define QPU_CONF_SIGMODE 1
`define QPU_CONF_CAPMODE 2
`define QPU_CONF_INXRES  3
`define QPU_NFLAG        8
`define QPU_FL_INX       0
`define QPU_FL_TIM       1
`define QPU_FL_VELC      2
`define QPU_FL_DIRCH     3
`define QPU_FL_POS0      4
`define QPU_FL_REV       7

// ****************************************************************
// reset values
// ****************************************************************
`define QPU_RST_WORD     32'h0000_0000
`define QPU_RST_MAXPOS   32'hffff_ffff
`define QPU_RST_VLOAD    32'h0000_ffff
`define QPU_RST_FILT     16'h0003
`define QPU_ONE32        32'h0000_0001

`endif

// ### design/qpu_pkg.sv
// Purpose: shared types of the position unit
// Assumes: qpu_map.svh holds the numbers
// Notes:   register request and encoder pins bundled as structs
package qpu_pkg;
    `include "qpu_map.svh"

    // register port request
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [`QPU_AW-1:0]   addr;
        logic [31:0]          wdata;
    } qpu_req_t;

    // raw encoder pins
    typedef struct packed {
        logic pha;
        logic phb;
        logic idx;
    } qpu_pins_t;
endpackage

// ### design/qpu_top.sv
// Purpose: quadrature position unit: decode, position, index, velocity
// Assumes: encoder pins asynchronous; register port on mclk
// Notes:   sticky flags, set wins over clear
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Function
// R1: phase order gives direction; count up one way, down the other
// R2: resolution selectable as two or four counts per quadrature cycle
// R3: optionally clear position counter on an index pulse
// R4: timer period captures position pulse count as velocity
// R5: interrupt when captured velocity below programmed compare value
// R6: position and velocity results are 32-bit registers
// R7: three position compare values, each with its own equality flag
// R8: separate index pulse counter gives revolution count
// R9: revolution count compared to programmed value, flag on match; the code flags it only together with the cmp0 position match
// R10: index match combined with position match raises one flag
// R11: each input filtered, accepted after programmable stable cycles
// R12: alternative count-pulse and direction-level input mode
// R13: 4x counts every A and B edge; 2x only A edges
// R14: sticky flags cleared by software; enabled ones drive interrupt
module qpu_top #(
    parameter int FW = 16  // filter counter width
) (
    input  wire logic              mclk,   // peripheral clock, 25 MHz
    input  wire logic              rst,    // async reset, high
    input  wire qpu_pkg::qpu_req_t req,    // register request
    output logic [31:0]            rdata,  // read data, cycle after rd
    input  wire qpu_pkg::qpu_pins_t pins,  // encoder pins
    output logic                   irq,    // interrupt, high
    output logic                   dir_out // current direction
);
    import qpu_pkg::*;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [3:0]          conf_reg;
    logic [FW-1:0]       filt_reg;
    logic [31:0]         maxpos_reg;
    logic [31:0]         cmp_reg [3];
    logic [31:0]         idxcmp_reg;
    logic [31:0]         vload_reg;
    logic [31:0]         vcmp_reg;
    logic [`QPU_NFLAG-1:0] ien_reg;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0]         pos_reg;
    logic [31:0]         idx_reg;
    logic [31:0]         vtime_reg;
    logic [31:0]         vel_reg;
    logic [31:0]         vcap_reg;
    logic [`QPU_NFLAG-1:0] stat_reg;
    logic                fa_d_reg;
    logic                fb_d_reg;
    logic                fi_d_reg;

    logic                fa;
    logic                fb;
    logic                fi;
    logic                ctl_wr;
    logic                clr_wr;
    logic                step;
    logic                up;
    logic                idx_pulse;
    logic                tim_end;
    logic [2:0]          pos_hit;
    logic                idx_hit;
    logic [`QPU_NFLAG-1:0] ev;

    // write decode helper
    function automatic logic wr_at(input logic [`QPU_AW-1:0] ofs);
        return req.wr && req.addr == ofs;
    endfunction

    assign ctl_wr = wr_at(`QPU_OFS_CTRL);
    assign clr_wr = wr_at(`QPU_OFS_CLR);

    // ****************************************************************
    // input filters
    // ****************************************************************
    qpu_filter #(.FW(FW)) u_fa (
        .mclk    (mclk),
        .rst     (rst),
        .din     (pins.pha),
        .flt_len (filt_reg),
        .dout    (fa)
    );
    qpu_filter #(.FW(FW)) u_fb (
        .mclk    (mclk),
        .rst     (rst),
        .din     (pins.phb),
        .flt_len (filt_reg),
        .dout    (fb)
    );
    qpu_filter #(.FW(FW)) u_fi (
        .mclk    (mclk),
        .rst     (rst),
        .din     (pins.idx),
        .flt_len (filt_reg),
        .dout    (fi)
    );

    // edge memories of filtered levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fa_d_reg <= 1'b0;
            fb_d_reg <= 1'b0;
            fi_d_reg <= 1'b0;
        end else begin
            fa_d_reg <= fa;
            fb_d_reg <= fb;
            fi_d_reg <= fi;
        end
    end

    // ****************************************************************
    // decoder
    // ****************************************************************
    // A leading B counts up; clk/dir mode counts A rising
    always_comb begin
        step = 1'b0;
        up   = 1'b0;
        if (conf_reg[`QPU_CONF_SIGMODE]) begin
            step = fa & ~fa_d_reg;                        // [R12]
            up   = fb;                                    // [R12]
        end else begin
            if (fa != fa_d_reg) begin
                step = 1'b1;                              // [R13]
                up   = fa ^ fb;                           // [R1]
            end else if (fb != fb_d_reg) begin
                step = conf_reg[`QPU_CONF_CAPMODE];       // [R2] [R13]
                up   = ~(fa ^ fb);                        // [R1]
            end
        end
        up = up ^ conf_reg[`QPU_CONF_DIRINV];
    end

    assign idx_pulse = fi & ~fi_d_reg;

    // ****************************************************************
    // position counter
    // ****************************************************************
    // wraps within 0..maxpos
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pos_reg <= `QPU_RST_WORD;
        end else if ((ctl_wr && req.wdata[`QPU_CTRL_RESP]) ||
                     (idx_pulse && conf_reg[`QPU_CONF_INXRES])) begin
            pos_reg <= `QPU_RST_WORD;                     // [R3]
        end else if (step && up) begin
            pos_reg <= (pos_reg >= maxpos_reg) ? `QPU_RST_WORD
                                               : pos_reg + `QPU_ONE32; // [R1] [R6]
        end else if (step) begin
            pos_reg <= (pos_reg == `QPU_RST_WORD) ? maxpos_reg
                                                  : pos_reg - `QPU_ONE32; // [R1]
        end
    end

    // direction of last step
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_out <= 1'b0;
        end else if (step) begin
            dir_out <= up;
        end
    end

    // ****************************************************************
    // index counter
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idx_reg <= `QPU_RST_WORD;
        end else if (ctl_wr && req.wdata[`QPU_CTRL_RESI]) begin
            idx_reg <= `QPU_RST_WORD;
        end else if (idx_pulse) begin
            idx_reg <= idx_reg + `QPU_ONE32;              // [R8]
        end
    end

    // ****************************************************************
    // velocity timer
    // ****************************************************************
    // reloads from vload: period of vload+1 cycles
    assign tim_end = (vtime_reg == `QPU_RST_WORD);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vtime_reg <= `QPU_RST_VLOAD;
        end else if (tim_end || (ctl_wr && req.wdata[`QPU_CTRL_RESV])) begin
            vtime_reg <= vload_reg;                       // [R4]
        end else begin
            vtime_reg <= vtime_reg - `QPU_ONE32;
        end
    end

    // pulse counter and capture
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vel_reg  <= `QPU_RST_WORD;
            vcap_reg <= `QPU_RST_WORD;
        end else if (tim_end) begin
            vcap_reg <= vel_reg + {31'h0, step};          // [R4] [R6]
            vel_reg  <= `QPU_RST_WORD;
        end else if (ctl_wr && req.wdata[`QPU_CTRL_RESV]) begin
            vel_reg  <= `QPU_RST_WORD;
        end else if (step) begin
            vel_reg  <= vel_reg + `QPU_ONE32;
        end
    end

    // ****************************************************************
    // compares and events
    // ****************************************************************
    // level compares on the present count
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pos_hit[i] = (pos_reg == cmp_reg[i]);         // [R7]
        end
        idx_hit = (idx_reg == idxcmp_reg);                // [R9]
        ev = '0;
        ev[`QPU_FL_INX]   = idx_pulse;
        ev[`QPU_FL_TIM]   = tim_end;
        ev[`QPU_FL_VELC]  = tim_end && (vcap_reg < vcmp_reg); // [R5]
        ev[`QPU_FL_DIRCH] = step && (up != dir_out);
        ev[`QPU_FL_POS0 +: 3] = pos_hit;                  // [R7]
        ev[`QPU_FL_REV]   = idx_hit && pos_hit[0];        // [R9] [R10]
    end

    // sticky flags; set beats clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= ev | (stat_reg & ~(clr_wr ? req.wdata[`QPU_NFLAG-1:0]
                                                  : {`QPU_NFLAG{1'b0}})); // [R14]
        end
    end

    // registered interrupt of enabled flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & ien_reg);                 // [R14]
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conf_reg   <= '0;
            filt_reg   <= `QPU_RST_FILT;
            maxpos_reg <= `QPU_RST_MAXPOS;
            cmp_reg[0] <= `QPU_RST_WORD;
            cmp_reg[1] <= `QPU_RST_WORD;
            cmp_reg[2] <= `QPU_RST_WORD;
            idxcmp_reg <= `QPU_RST_WORD;
            vload_reg  <= `QPU_RST_VLOAD;
            vcmp_reg   <= `QPU_RST_WORD;
            ien_reg    <= '0;
        end else if (req.wr) begin
            case (req.addr)
                `QPU_OFS_CONF:   conf_reg   <= req.wdata[3:0];
                `QPU_OFS_FILT:   filt_reg   <= req.wdata[FW-1:0]; // [R11]
                `QPU_OFS_MAXPOS: maxpos_reg <= req.wdata;
                `QPU_OFS_CMP0:   cmp_reg[0] <= req.wdata;
                `QPU_OFS_CMP1:   cmp_reg[1] <= req.wdata;
                `QPU_OFS_CMP2:   cmp_reg[2] <= req.wdata;
                `QPU_OFS_IDXCMP: idxcmp_reg <= req.wdata;
                `QPU_OFS_VLOAD:  vload_reg  <= req.wdata;
                `QPU_OFS_VCMP:   vcmp_reg   <= req.wdata; // [R5]
                `QPU_OFS_IEN:    ien_reg    <= req.wdata[`QPU_NFLAG-1:0];
                default:         ;
            endcase
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    // unmapped and write-only addresses read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= `QPU_RST_WORD;
        end else if (req.rd) begin
            case (req.addr)
                `QPU_OFS_CONF:   rdata <= {28'h0, conf_reg};
                `QPU_OFS_FILT:   rdata <= 32'(filt_reg);
                `QPU_OFS_POS:    rdata <= pos_reg;
                `QPU_OFS_MAXPOS: rdata <= maxpos_reg;
                `QPU_OFS_CMP0:   rdata <= cmp_reg[0];
                `QPU_OFS_CMP1:   rdata <= cmp_reg[1];
                `QPU_OFS_CMP2:   rdata <= cmp_reg[2];
                `QPU_OFS_IDX:    rdata <= idx_reg;
                `QPU_OFS_IDXCMP: rdata <= idxcmp_reg;
                `QPU_OFS_VLOAD:  rdata <= vload_reg;
                `QPU_OFS_VTIME:  rdata <= vtime_reg;
                `QPU_OFS_VEL:    rdata <= vel_reg;
                `QPU_OFS_VCAP:   rdata <= vcap_reg;
                `QPU_OFS_VCMP:   rdata <= vcmp_reg;
                `QPU_OFS_DIR:    rdata <= {31'h0, dir_out};
                `QPU_OFS_STAT:   rdata <= {24'h0, stat_reg};
                `QPU_OFS_IEN:    rdata <= {24'h0, ien_reg};
                default:         rdata <= `QPU_RST_WORD;
            endcase
        end else begin
            rdata <= `QPU_RST_WORD;
        end
    end
endmodule

// ### dv/qpu_top_chk.sv
// Purpose: port-level checker of the position unit
// Assumes: register port and irq timing of the device
// Notes:   ien shadowed to tie irq to its cause
`timescale 1ns/1ps
`include "qpu_map.svh"
module qpu_top_chk (
    input wire logic               mclk,    // peripheral clock
    input wire logic               rst,     // async reset, high
    input wire qpu_pkg::qpu_req_t  req,     // register request
    input wire logic [31:0]        rdata,   // read data
    input wire qpu_pkg::qpu_pins_t pins,    // encoder pins
    input wire logic               irq,     // interrupt
    input wire logic               dir_out  // direction
);
    import qpu_pkg::*;
    logic [7:0] ien_reg;
    logic       clrw;
    logic       rw_hit;

    // ****************************************************************
    // helper logic
    // ****************************************************************
    // shadow of the enable mask
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ien_reg <= 8'h00;
        end else if (req.wr && req.addr == `QPU_OFS_IEN) begin
            ien_reg <= req.wdata[7:0];
        end
    end
    // irq-lowering writes; full-width r/w registers
    assign clrw   = req.wr && (req.addr == `QPU_OFS_IEN || req.addr == `QPU_OFS_CLR);
    assign rw_hit = req.wr && (req.addr inside {`QPU_OFS_MAXPOS, `QPU_OFS_CMP0,
                    `QPU_OFS_CMP1, `QPU_OFS_CMP2, `QPU_OFS_IDXCMP, `QPU_OFS_VLOAD,
                    `QPU_OFS_VCMP});

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // assertions
    // ****************************************************************
    rdata_idle_a: assert property (
        !$past(req.rd) |-> rdata == 32'h0) else $error("rdata not idle");
    unmapped_rd_a: assert property (
        req.rd && req.addr > `QPU_OFS_IEN |=> rdata == 32'h0) else $error("unmapped read");
    clr_rd_a: assert property (
        req.rd && req.addr == `QPU_OFS_CLR |=> rdata == 32'h0) else $error("clear reg read");
    rw_readback_a: assert property (
        rw_hit ##2 (req.rd && req.addr == $past(req.addr, 2))
        |=> rdata == $past(req.wdata, 3)) else $error("read-back differs");
    dir_read_a: assert property (
        req.rd && req.addr == `QPU_OFS_DIR |=> rdata[0] == $past(dir_out))
        else $error("dir read differs");
    irq_off_a: assert property (
        req.wr && req.addr == `QPU_OFS_IEN && req.wdata == 32'h0 |=> ##1 !irq)
        else $error("irq with mask clear");
    irq_cause_a: assert property (
        irq |-> $past(ien_reg) != 8'h00) else $error("irq with no enable");
    irq_hold_a: assert property (
        irq && !$past(clrw) |=> irq) else $error("irq dropped");
endmodule

// ### dv/qpu_top_tb_top.sv
// Purpose: self-checking bench for the position unit
// Assumes: wheel model on the pins
// Notes:   reads sampled mid-cycle
`timescale 1ns/1ps
`include "qpu_map.svh"
module qpu_top_tb_top;
    import qpu_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    qpu_req_t    req = '0;
    qpu_pins_t   pins;
    logic [31:0] rdata;
    logic        irq;
    logic        dir_out;
    logic        step = 1'b0;
    logic        up = 1'b1;
    logic        cd = 1'b0;
    logic        index = 1'b0;
    logic [7:0]  plen = 8'h05;
    int          num_errors = 0;
    int          tests_run = 0;

    always #20 mclk = ~mclk;

    qpu_top #(.FW(16)) dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
        .pins(pins), .irq(irq), .dir_out(dir_out));
    qpu_wheel u_wheel (.mclk(mclk), .rst(rst), .step(step), .up(up), .cd(cd),
        .index(index), .plen(plen), .pins(pins));

    // ****************************************************************
    // bus and stimulus tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask
    // idle cycle between strobes
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        req <= '0;
        @(negedge mclk);
        check(rdata & m, e);
        @(posedge mclk);
    endtask
    task automatic irq_is(input logic e);
        @(negedge mclk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge mclk);
    endtask
    // gap above pulse plus filter hold
    task automatic steps(input int n, input logic u, input int gap);
        up <= u;
        repeat (n) begin
            @(posedge mclk);
            step <= 1'b1;
            @(posedge mclk);
            step <= 1'b0;
            repeat (gap - 2) @(posedge mclk);
        end
        repeat (30) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(`QPU_OFS_MAXPOS, ALL, ALL);
        rd(`QPU_OFS_VLOAD, ALL, 32'hffff);
        rd(`QPU_OFS_FILT, ALL, 32'h3);
        rd(`QPU_OFS_POS, ALL, 32'h0);
        rd(`QPU_OFS_CLR, ALL, 32'h0);
        rd(5'h1f, ALL, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_quad();
        wr(`QPU_OFS_FILT, 32'h0);
        wr(`QPU_OFS_CONF, 32'h4);
        wr(`QPU_OFS_CTRL, 32'h1);
        steps(8, 1'b1, 12);
        rd(`QPU_OFS_POS, ALL, 32'h8);
        irq_is(1'b0);
        rd(`QPU_OFS_DIR, 32'h1, 32'h1);
        check({31'h0, dir_out}, 32'h1);
        steps(3, 1'b0, 12);
        rd(`QPU_OFS_POS, ALL, 32'h5);
        rd(`QPU_OFS_DIR, 32'h1, 32'h0);
        // wrap both ends
        wr(`QPU_OFS_MAXPOS, 32'h5);
        wr(`QPU_OFS_CTRL, 32'h1);
        steps(1, 1'b0, 12);
        rd(`QPU_OFS_POS, ALL, 32'h5);
        steps(1, 1'b1, 12);
        rd(`QPU_OFS_POS, ALL, 32'h0);
        wr(`QPU_OFS_MAXPOS, ALL);
        wr(`QPU_OFS_CONF, 32'h1);
        wr(`QPU_OFS_CTRL, 32'h1);
        steps(8, 1'b1, 12);
        rd(`QPU_OFS_POS, ALL, 32'hffff_fffc);
        $display("test quadrature done");
    endtask
    task automatic t_filter();
        wr(`QPU_OFS_FILT, 32'ha);
        wr(`QPU_OFS_CONF, 32'h2);
        cd <= 1'b1;
        wr(`QPU_OFS_CTRL, 32'h1);
        steps(1, 1'b1, 40);
        rd(`QPU_OFS_POS, ALL, 32'h0);
        plen <= 8'h14;
        steps(2, 1'b1, 40);
        steps(1, 1'b0, 40);
        rd(`QPU_OFS_POS, ALL, 32'h1);
        wr(`QPU_OFS_FILT, 32'h0);
        wr(`QPU_OFS_CONF, 32'h4);
        cd <= 1'b0;
        $display("test filter done");
    endtask
    task automatic t_cmp();
        for (int i = 0; i < 3; i++) begin
            wr(`QPU_OFS_CTRL, 32'h1);
            wr(5'(`QPU_OFS_CMP0 + i), 32'(5 + i));
            wr(`QPU_OFS_CLR, 32'hff);
            steps(5 + i, 1'b1, 12);
            steps(1, 1'b1, 12);
            rd(`QPU_OFS_STAT, 32'(16 << i), 32'(16 << i));
        end
        wr(`QPU_OFS_IEN, 32'h40);
        irq_is(1'b1);
        wr(`QPU_OFS_CLR, 32'h40);
        irq_is(1'b0);
        rd(`QPU_OFS_STAT, 32'h40, 32'h0);
        wr(`QPU_OFS_IEN, 32'h20);
        irq_is(1'b1);
        wr(`QPU_OFS_IEN, 32'h0);
        irq_is(1'b0);
        $display("test compare done");
    endtask
    task automatic t_index();
        wr(`QPU_OFS_CONF, 32'hc);
        wr(`QPU_OFS_CTRL, 32'h3);
        wr(`QPU_OFS_CMP0, 32'h2);
        wr(`QPU_OFS_IDXCMP, 32'h1);
        steps(3, 1'b1, 12);
        index <= 1'b1;
        repeat (10) @(posedge mclk);
        index <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(`QPU_OFS_POS, ALL, 32'h0);
        rd(`QPU_OFS_IDX, ALL, 32'h1);
        rd(`QPU_OFS_STAT, 32'h1, 32'h1);
        wr(`QPU_OFS_CLR, 32'hff);
        steps(2, 1'b1, 12);
        rd(`QPU_OFS_STAT, 32'h90, 32'h90);
        wr(`QPU_OFS_IDXCMP, 32'h2);
        steps(1, 1'b1, 12);
        wr(`QPU_OFS_CLR, 32'hff);
        steps(1, 1'b0, 12);
        rd(`QPU_OFS_STAT, 32'h98, 32'h18);
        $display("test index done");
    endtask
    task automatic t_vel();
        wr(`QPU_OFS_CONF, 32'h4);
        wr(`QPU_OFS_VLOAD, 32'h77);
        wr(`QPU_OFS_CTRL, 32'h4);
        wr(`QPU_OFS_VCMP, 32'h5);
        rd(`QPU_OFS_VCMP, ALL, 32'h5);
        // ten steps per 120-cycle period
        fork
            steps(60, 1'b1, 12);
            begin
                repeat (400) @(posedge mclk);
                rd(`QPU_OFS_VCAP, ALL, 32'ha);
                wr(`QPU_OFS_CLR, 32'h4);
                repeat (150) @(posedge mclk);
                rd(`QPU_OFS_STAT, 32'h4, 32'h0);
            end
        join
        repeat (400) @(posedge mclk);
        rd(`QPU_OFS_STAT, 32'h6, 32'h6);
        $display("test velocity done");
    endtask

    // ****************************************************************
    // run control
    // ****************************************************************
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        $display("[FAIL] %0t ns: timeout", $time);
        summarize();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_quad();
        t_filter();
        t_cmp();
        t_index();
        t_vel();
        summarize();
    end
endmodule

bind qpu_top qpu_top_chk u_chk (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .pins(pins), .irq(irq), .dir_out(dir_out));

// ### dv/qpu_wheel.sv
// Purpose: encoder wheel model driving phase and index pins
// Assumes: steps spaced by the bench
// Notes:   count/direction signalling on request
`timescale 1ns/1ps
module qpu_wheel (
    input  wire logic          mclk,   // bench clock
    input  wire logic          rst,    // async reset, high
    input  wire logic          step,   // one-cycle step request
    input  wire logic          up,     // step direction
    input  wire logic          cd,     // count/direction signalling
    input  wire logic          index,  // index channel level
    input  wire logic [7:0]    plen,   // count pulse length
    output qpu_pkg::qpu_pins_t pins    // encoder pins
);
    import qpu_pkg::*;
    logic [1:0] q_reg;    // {a, b}
    logic [7:0] cnt_reg;  // count pulse remaining

    // ****************************************************************
    // wheel motion
    // ****************************************************************
    // a leads b going up, b leads a going down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q_reg <= 2'h0;
        end else if (step && !cd) begin
            q_reg <= up ? {~q_reg[0], q_reg[1]} : {q_reg[0], ~q_reg[1]};
        end
    end
    // count pulse; short ones probe the filter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
        end else if (step && cd) begin
            cnt_reg <= plen;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    // one driver for the whole struct
    assign pins = '{pha: cd ? (cnt_reg != 8'h00) : q_reg[1],
                    phb: cd ? up : q_reg[0], idx: index};
endmodule
